// ==== asd_serial_status.sv ====
`timescale 1ns/1ns
`include "asd_defines.svh"

// Notes on behaviour
// - Noise enable bit gates noise flag onto error request; reset clears it.
// - Framing enable bit gates framing flag onto error request; reset clears it.
// - Parity enable bit gates parity flag onto error request; reset clears it.
// - Tx-empty sets on shift load, clears by armed status read then data write.
// - Tx-done is set while tx-empty set and nothing shifts out; reset sets.
// - Tx-done clears as soon as data, preamble or break is queued.
// - Rx-full sets on data move, clears by armed status read then data read.
// - Idle sets on idle detect, clears by armed status read then data read.
// - Idle may set only after a character set rx-full since enable or clear.
// - Overrun sets when a character completes while full; new character dropped.
// - Data read clears overrun only if it was set at the status read.
// - Noise flag sets on noise; status read then data read clears it.
// - Framing flag sets on zero stop bit; armed sequence clears it.
// - Parity flag sets on parity failure; armed sequence clears it.
// - Break sets break, framing, rx-full; clears ninth bit in nine-bit mode.
// - Break clears via status two then data read; rearms after line high.
// - Rx-active sets on zero in first sample slot; false start or idle clears.
// - Data address reads received byte, writes transmit byte; reset keeps it.
// - Overrun enable bit gates overrun flag onto error request.
// - Ninth bit captured together with the eight data bits.

module asd_serial_status
  import asd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // CPU side
  input  wire asd_pkg::asd_addr_t busAddr,
  input  wire logic              busRd,
  input  wire logic              busWr,
  input  wire asd_pkg::asd_byte_t busWdata,
  output asd_pkg::asd_byte_t     busRdata,
  // Enables held in control two
  input  wire logic              tx_empty_irq_enable,
  input  wire logic              tx_done_irq_enable,
  input  wire logic              rx_full_irq_enable,
  input  wire logic              line_quiet_irq_enable,
  input  wire logic              rxEnable,
  input  wire logic              nineBitMode,
  // Receive engine events
  input  wire logic              rxCharDone,
  input  wire asd_pkg::asd_byte_t rxShiftData,
  input  wire logic              rxShiftNinth,
  input  wire logic              rxParityErr,
  input  wire logic              noise_fault_bit,
  input  wire logic              rxStopZero,
  input  wire logic              rxBreakSeen,
  input  wire logic              rxIdleSeen,
  input  wire logic              first_sample_slot,
  input  wire logic              rxFalseStart,
  input  wire logic              rx_pin,
  // Transmit engine events
  input  wire logic              txShiftLoad,
  input  wire logic              txShifting,
  input  wire logic              txQueued,
  output asd_pkg::asd_byte_t     txData,
  output logic                   txNinth,
  output logic                   txEmpty,
  // Requests
  output logic                   errIrq,
  output logic                   txIrq,
  output logic                   rxIrq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire hitCtrl3 = (busAddr == `ASD_ADDR_CTRL3);
  wire hitStat1 = (busAddr == `ASD_ADDR_STAT1);
  wire hitStat2 = (busAddr == `ASD_ADDR_STAT2);
  wire hitData  = (busAddr == `ASD_ADDR_DATA);

  wire rdStat1 = busRd && hitStat1;
  wire rdStat2 = busRd && hitStat2;
  wire rdData  = busRd && hitData;
  wire wrData  = busWr && hitData;
  wire wrCtrl3 = busWr && hitCtrl3;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic      rxPinMeta_q;
  logic      rxPinSync_q;
  logic      rxPinPrev_q;
  logic      rxEnable_q;
  logic      idleAllowed_q;
  logic      idleAllowed_d;
  logic      breakAllowed_q;
  logic      breakAllowed_d;
  logic      rxActive_q;
  logic      rxActive_d;
  logic      txDone_q;
  logic      txDone_d;
  logic      overrunEn_q;
  logic      noiseEn_q;
  logic      framingEn_q;
  logic      parityEn_q;
  logic      dmaRx_q;
  logic      dmaTx_q;
  logic      txNinth_q;
  logic      rxNinth_q;
  asd_byte_t rxData_q;
  asd_byte_t txData_q;
  asd_byte_t busRdata_q;
  logic      errIrq_q;
  logic      txIrq_q;
  logic      rxIrq_q;

  logic [`ASD_FLAGS-1:0] flagSet;
  logic [`ASD_FLAGS-1:0] flagArm;
  logic [`ASD_FLAGS-1:0] flagClr;
  logic [`ASD_FLAGS-1:0] flagVal;
  logic [`ASD_FLAGS-1:0] flagArmed;

  // ----------------------------------------------------------------
  // Receive events
  // ----------------------------------------------------------------
  wire rxFull     = flagVal[`ASD_F_RXF];
  wire breakSet   = rxBreakSeen && breakAllowed_q;
  wire overrunSet = rxCharDone && rxFull;
  wire charTaken  = rxCharDone && !rxFull;
  wire idleSet    = rxIdleSeen && idleAllowed_q;
  wire rxEnRise   = rxEnable && !rxEnable_q;
  wire rxPinRise  = rxPinSync_q && !rxPinPrev_q;
  wire idleCleared = flagVal[`ASD_F_IDLE] && rdData && flagArmed[`ASD_F_IDLE];

  assign flagSet[`ASD_F_PAR]  = rxCharDone && rxParityErr;
  assign flagSet[`ASD_F_FRM]  = (rxCharDone && rxStopZero) || breakSet;
  assign flagSet[`ASD_F_NSE]  = rxCharDone && noise_fault_bit;
  assign flagSet[`ASD_F_OVR]  = overrunSet;
  assign flagSet[`ASD_F_IDLE] = idleSet;
  assign flagSet[`ASD_F_RXF]  = charTaken || breakSet;
  assign flagSet[`ASD_F_BRK]  = breakSet;
  assign flagSet[`ASD_F_TXE]  = txShiftLoad;

  // Break arms from status two; all others from status one
  assign flagArm[`ASD_F_BRK] = rdStat2;
  assign flagClr[`ASD_F_TXE] = wrData;
  assign flagClr[`ASD_F_BRK] = rdData;

  genvar gi;
  generate
    for (gi = 0; gi < `ASD_FLAGS; gi++) begin : g_flag
      if (gi != `ASD_F_BRK) begin : g_arm1
        assign flagArm[gi] = rdStat1;
      end
      if ((gi != `ASD_F_BRK) && (gi != `ASD_F_TXE)) begin : g_clrd
        assign flagClr[gi] = rdData;
      end
      asd_flag_cell #(
        .RESET_VAL  ((gi == `ASD_F_TXE) ? `ASD_RST_TXE : 1'b0),
        .ARM_ALWAYS (gi == `ASD_F_NSE)
      ) u_cell (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .setEv    (flagSet[gi]),
        .armEv    (flagArm[gi]),
        .clrEv    (flagClr[gi]),
        .flag     (flagVal[gi]),
        .armed    (flagArmed[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Qualifiers for idle, break and reception in progress
  // ----------------------------------------------------------------
  // Gate reopens only after a real character, not after a break
  assign idleAllowed_d  = charTaken ? 1'b1 : ((rxEnRise || idleCleared) ? 1'b0 : idleAllowed_q);
  // Rearm on a rising edge only: the synced level still shows
  // the line high for two cycles after a break pulse
  assign breakAllowed_d = breakSet ? 1'b0 : (rxPinRise ? 1'b1 : breakAllowed_q);
  assign rxActive_d     = first_sample_slot ? 1'b1 : ((rxFalseStart || rxIdleSeen) ? 1'b0 : rxActive_q);
  // Queueing drops tx-done at once, before the line really moves
  assign txDone_d       = flagVal[`ASD_F_TXE] && !txShifting && !txQueued && !wrData;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxPinMeta_q    <= 1'b1;
      rxPinSync_q    <= 1'b1;
      rxPinPrev_q    <= 1'b1;
      rxEnable_q     <= 1'b0;
      idleAllowed_q  <= 1'b0;
      breakAllowed_q <= 1'b1;
      rxActive_q     <= 1'b0;
      txDone_q       <= `ASD_RST_TC;
    end else if (ce) begin
      rxPinMeta_q    <= rx_pin;
      rxPinSync_q    <= rxPinMeta_q;
      rxPinPrev_q    <= rxPinSync_q;
      rxEnable_q     <= rxEnable;
      idleAllowed_q  <= idleAllowed_d;
      breakAllowed_q <= breakAllowed_d;
      rxActive_q     <= rxActive_d;
      txDone_q       <= txDone_d;
    end
  end

  // ----------------------------------------------------------------
  // Control three
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overrunEn_q <= 1'b0;
      noiseEn_q   <= 1'b0;
      framingEn_q <= 1'b0;
      parityEn_q  <= 1'b0;
      dmaRx_q     <= 1'b0;
      dmaTx_q     <= 1'b0;
    end else if (ce && wrCtrl3) begin
      overrunEn_q <= busWdata[`ASD_C3_OVERRUN_IRQ_ENABLE];
      noiseEn_q   <= busWdata[`ASD_C3_NOISE_IRQ_ENABLE];
      framingEn_q <= busWdata[`ASD_C3_FRAMING_IRQ_ENABLE];
      parityEn_q  <= busWdata[`ASD_C3_PARITY_IRQ_ENABLE];
      dmaRx_q     <= busWdata[`ASD_C3_DMARX];
      dmaTx_q     <= busWdata[`ASD_C3_DMATX];
    end
  end

  // ----------------------------------------------------------------
  // Data storage, untouched by reset
  // ----------------------------------------------------------------
  wire [7:0] rxByteIn  = breakSet ? `ASD_BYTE_ZERO : rxShiftData;
  wire       rxNinthIn = breakSet ? 1'b0 : (nineBitMode ? rxShiftNinth : rxShiftData[7]);
  wire       rxLoad    = charTaken || breakSet;

  always_ff @(posedge core_clk) begin
    if (ce && rxLoad) begin
      rxData_q  <= rxByteIn;
      rxNinth_q <= rxNinthIn;
    end
    if (ce && wrData) begin
      txData_q  <= busWdata;
    end
    if (ce && wrCtrl3) begin
      txNinth_q <= busWdata[`ASD_C3_TX9];
    end
  end

  // ----------------------------------------------------------------
  // Read mux and requests
  // ----------------------------------------------------------------
  wire [7:0] ctrl3Val = {rxNinth_q, txNinth_q, dmaRx_q, dmaTx_q,
                         overrunEn_q, noiseEn_q, framingEn_q, parityEn_q};
  wire [7:0] stat1Val = {flagVal[`ASD_F_TXE], txDone_q, flagVal[`ASD_F_RXF], flagVal[`ASD_F_IDLE],
                         flagVal[`ASD_F_OVR], flagVal[`ASD_F_NSE], flagVal[`ASD_F_FRM], flagVal[`ASD_F_PAR]};
  wire [7:0] stat2Val = {6'h00, flagVal[`ASD_F_BRK], rxActive_q};
  wire [7:0] readMux  = hitCtrl3 ? ctrl3Val :
                        hitStat1 ? stat1Val :
                        hitStat2 ? stat2Val :
                        hitData  ? rxData_q : `ASD_BYTE_ZERO;

  // Break flag is left out of every request
  wire errSrc = (flagVal[`ASD_F_OVR] && overrunEn_q) ||
                (flagVal[`ASD_F_NSE] && noiseEn_q)   ||
                (flagVal[`ASD_F_FRM] && framingEn_q) ||
                (flagVal[`ASD_F_PAR] && parityEn_q);
  wire txSrc  = (flagVal[`ASD_F_TXE] && tx_empty_irq_enable) || (txDone_q && tx_done_irq_enable);
  wire rxSrc  = (flagVal[`ASD_F_RXF] && rx_full_irq_enable) ||
                (flagVal[`ASD_F_IDLE] && line_quiet_irq_enable);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busRdata_q <= `ASD_BYTE_ZERO;
      errIrq_q   <= 1'b0;
      txIrq_q    <= 1'b0;
      rxIrq_q    <= 1'b0;
    end else if (ce) begin
      if (busRd) begin
        busRdata_q <= readMux;
      end
      errIrq_q <= errSrc;
      txIrq_q  <= txSrc;
      rxIrq_q  <= rxSrc;
    end
  end

  assign busRdata = busRdata_q;
  assign txData   = txData_q;
  assign txNinth  = txNinth_q;
  assign txEmpty  = flagVal[`ASD_F_TXE];
  assign errIrq   = errIrq_q;
  assign txIrq    = txIrq_q;
  assign rxIrq    = rxIrq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_ovr_keeps_data: assert property (ce && overrunSet |=> flagVal[`ASD_F_OVR] && $stable(rxData_q))
    else $error("overrun lost flag or changed data");
  chk_ovr_late_read: assert property (ce && rdData && !flagArmed[`ASD_F_OVR] && flagVal[`ASD_F_OVR]
                                      |=> flagVal[`ASD_F_OVR])
    else $error("overrun cleared without armed status read");
  chk_noise_irq_path: assert property (ce && flagVal[`ASD_F_NSE] && noiseEn_q |=> errIrq_q)
    else $error("noise did not raise error request");
  chk_frame_irq_path: assert property (ce && flagVal[`ASD_F_FRM] && framingEn_q |=> errIrq_q)
    else $error("framing did not raise error request");
  chk_parity_irq_path: assert property (ce && flagVal[`ASD_F_PAR] && parityEn_q |=> errIrq_q)
    else $error("parity did not raise error request");
  chk_err_irq_drop: assert property (ce && !errSrc |=> !errIrq_q)
    else $error("error request without enabled flag");
  chk_break_sets: assert property (ce && breakSet |=> flagVal[`ASD_F_BRK] && flagVal[`ASD_F_FRM]
                                   && flagVal[`ASD_F_RXF] && !rxNinth_q)
    else $error("break did not set companions");
  chk_done_on_queue: assert property (ce && txQueued |=> !txDone_q)
    else $error("tx done stayed set after queueing");
  chk_idle_gated: assert property (ce && rxIdleSeen && !idleAllowed_q && !flagVal[`ASD_F_IDLE]
                                   |=> !flagVal[`ASD_F_IDLE])
    else $error("idle set before a valid character");
  chk_txe_clear_seq: assert property (ce && rdStat1 && flagVal[`ASD_F_TXE] ##1 ce && wrData && !txShiftLoad
                                      |=> !flagVal[`ASD_F_TXE])
    else $error("tx empty not cleared by sequence");
  chk_rx_irq_path: assert property (ce && rxFull && rx_full_irq_enable |=> rxIrq_q)
    else $error("receive full did not raise receive request");
  chk_idle_clear: assert property (ce && rdData && flagArmed[`ASD_F_IDLE] && !idleSet |=> !flagVal[`ASD_F_IDLE])
    else $error("idle not cleared by armed data read");
  chk_break_rearm: assert property (ce && rxBreakSeen && !breakAllowed_q && !flagVal[`ASD_F_BRK]
                                    |=> !flagVal[`ASD_F_BRK])
    else $error("break accepted before line returned high");
  chk_ovr_clear_armed: assert property (ce && rdData && flagArmed[`ASD_F_OVR] && !overrunSet
                                        |=> !flagVal[`ASD_F_OVR])
    else $error("overrun kept after armed data read");

  cov_overrun: cover property (ce && overrunSet);
  cov_rx_clear: cover property (rdStat1 && flagVal[`ASD_F_RXF] ##[1:20] rdData);
  cov_break: cover property (ce && breakSet);
  cov_idle_set: cover property (ce && idleSet);
  cov_tx_cycle: cover property (wrData ##[1:50] txShiftLoad);

endmodule

// ==== asd_defines.svh ====
`ifndef ASD_DEFINES_SVH
`define ASD_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ASD_ADDR_CTRL3  16'h0015
`define ASD_ADDR_STAT1  16'h0016
`define ASD_ADDR_STAT2  16'h0017
`define ASD_ADDR_DATA   16'h0018

// ----------------------------------------------------------------
// Control three fields
// ----------------------------------------------------------------
`define ASD_C3_RX9      7
`define ASD_C3_TX9      6
`define ASD_C3_DMARX    5
`define ASD_C3_DMATX    4
`define ASD_C3_OVERRUN_IRQ_ENABLE     3
`define ASD_C3_NOISE_IRQ_ENABLE     2
`define ASD_C3_FRAMING_IRQ_ENABLE     1
`define ASD_C3_PARITY_IRQ_ENABLE     0

// ----------------------------------------------------------------
// Flag cell indices (equal to status one bit positions, except break at 6)
// ----------------------------------------------------------------
`define ASD_FLAGS       8
`define ASD_F_PAR       0
`define ASD_F_FRM       1
`define ASD_F_NSE       2
`define ASD_F_OVR       3
`define ASD_F_IDLE      4
`define ASD_F_RXF       5
`define ASD_F_BRK       6
`define ASD_F_TXE       7

// ----------------------------------------------------------------
// Status two fields and reset values
// ----------------------------------------------------------------
`define ASD_S2_BRK      1
`define ASD_S2_RPF      0
`define ASD_BYTE_ZERO   8'h00
`define ASD_RST_TXE     1'b1
`define ASD_RST_TC      1'b1

`endif

// ==== asd_pkg.sv ====
package asd_pkg;
  typedef logic [7:0]  asd_byte_t;
  typedef logic [15:0] asd_addr_t;
endpackage

// ==== asd_flag_cell.sv ====
`timescale 1ns/1ns
`include "asd_defines.svh"

module asd_flag_cell #(
  parameter logic RESET_VAL  = 1'b0,
  parameter logic ARM_ALWAYS = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic setEv,
  input  wire logic armEv,
  input  wire logic clrEv,
  output logic      flag,
  output logic      armed
);

  logic flag_q;
  logic flag_d;
  logic armed_q;
  logic armed_d;

  // Set beats a clearing access in the same cycle
  assign flag_d  = setEv ? 1'b1 : ((clrEv && armed_q) ? 1'b0 : flag_q);
  // Arm only if the status read saw the flag set, or on every status read when ARM_ALWAYS
  assign armed_d = armEv ? (flag_q | ARM_ALWAYS) : (clrEv ? 1'b0 : armed_q);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q  <= RESET_VAL;
      armed_q <= 1'b0;
    end else if (ce) begin
      flag_q  <= flag_d;
      armed_q <= armed_d;
    end
  end

  assign flag  = flag_q;
  assign armed = armed_q;

endmodule

// ==== asd_engine_model.sv ====
`timescale 1ns/1ns

module asd_engine_model
  import asd_pkg::*;
(
  input  wire logic          core_clk,
  output logic               rxCharDone,
  output asd_pkg::asd_byte_t rxShiftData,
  output logic               rxShiftNinth,
  output logic               rxParityErr,
  output logic               noise_fault_bit,
  output logic               rxStopZero,
  output logic               rxBreakSeen,
  output logic               rxIdleSeen,
  output logic               first_sample_slot,
  output logic               rxFalseStart,
  output logic               rx_pin,
  output logic               txShiftLoad,
  output logic               txShifting,
  output logic               txQueued
);
  logic [3:0] ev;

  assign {rxBreakSeen, rxIdleSeen, first_sample_slot, rxFalseStart} = ev;

  initial begin
    ev = 4'h0;
    rxCharDone = 1'h0;
    rxShiftData = 8'h00;
    {rxShiftNinth, rxParityErr, noise_fault_bit, rxStopZero} = 4'h0;
    rx_pin = 1'h1;
    {txShiftLoad, txShifting, txQueued} = 3'h0;
  end

  // ----
  // Receive side
  // ----
  // Content is inverted outside the strobe so unqualified use shows up
  task automatic rxChar(input asd_byte_t d, input logic n, pe, nf, fe);
    @(posedge core_clk);
    rxCharDone <= 1'h1;
    rxShiftData <= d;
    {rxShiftNinth, rxParityErr, noise_fault_bit, rxStopZero} <= {n, pe, nf, fe};
    @(posedge core_clk);
    rxCharDone <= 1'h0;
    rxShiftData <= ~d;
    {rxShiftNinth, rxParityErr, noise_fault_bit, rxStopZero} <= ~{n, pe, nf, fe};
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'h1;
    @(posedge core_clk);
    ev[i] <= 1'h0;
  endtask

  // Line stays low after a break until lineHigh
  task automatic rxBreak();
    @(posedge core_clk);
    rx_pin <= 1'h0;
    ev[3] <= 1'h1;
    @(posedge core_clk);
    ev[3] <= 1'h0;
  endtask

  task automatic lineHigh();
    @(posedge core_clk);
    rx_pin <= 1'h1;
  endtask

  // ----
  // Transmit side
  // ----
  task automatic txLoad();
    @(posedge core_clk);
    {txShiftLoad, txQueued, txShifting} <= 3'h7;
    @(posedge core_clk);
    {txShiftLoad, txQueued} <= 2'h0;
  endtask

  task automatic txStop();
    @(posedge core_clk);
    txShifting <= 1'h0;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ns
`include "asd_defines.svh"

module testbench;
  import asd_pkg::*;
  typedef struct {
    asd_byte_t d;
    logic      pe;
    logic      nf;
    logic      fe;
    asd_byte_t en;
    asd_byte_t s1;
    logic      err;
  } asd_row_t;
  localparam asd_addr_t S1 = `ASD_ADDR_STAT1;
  localparam asd_addr_t S2 = `ASD_ADDR_STAT2;
  localparam asd_addr_t DR = `ASD_ADDR_DATA;
  localparam asd_addr_t C3 = `ASD_ADDR_CTRL3;
  localparam int        IDL = 2;
  localparam int        FSS = 1;
  localparam int        FLS = 0;
  logic      core_clk, rst, ce, busRd, busWr, rxEnable, nineBitMode, txNinth, txEmpty;
  logic      tx_empty_irq_enable, tx_done_irq_enable, rx_full_irq_enable, line_quiet_irq_enable;
  logic      rxCharDone, rxShiftNinth, rxParityErr, noise_fault_bit, rxStopZero, rxBreakSeen;
  logic      rxIdleSeen, first_sample_slot, rxFalseStart, rx_pin, txShiftLoad, txShifting;
  logic      txQueued, errIrq, txIrq, rxIrq;
  asd_addr_t busAddr;
  asd_byte_t busWdata, busRdata, rxShiftData, txData, rdv;
  int        err_count, num_checks;
  asd_row_t  rows [7] = '{'{8'h5a, 1'h0, 1'h0, 1'h0, 8'h0f, 8'he0, 1'h0},
                          '{8'ha5, 1'h1, 1'h0, 1'h0, 8'h01, 8'he1, 1'h1},
                          '{8'ha5, 1'h1, 1'h0, 1'h0, 8'h0e, 8'he1, 1'h0},
                          '{8'h3c, 1'h0, 1'h1, 1'h0, 8'h04, 8'he4, 1'h1},
                          '{8'h3c, 1'h0, 1'h1, 1'h0, 8'h0b, 8'he4, 1'h0},
                          '{8'hc3, 1'h0, 1'h0, 1'h1, 8'h02, 8'he2, 1'h1},
                          '{8'hc3, 1'h0, 1'h0, 1'h1, 8'h0d, 8'he2, 1'h0}};

  asd_serial_status u_asd_serial_status (
    .core_clk, .rst, .ce, .busAddr, .busRd, .busWr, .busWdata, .busRdata,
    .tx_empty_irq_enable, .tx_done_irq_enable, .rx_full_irq_enable, .line_quiet_irq_enable,
    .rxEnable, .nineBitMode, .rxCharDone, .rxShiftData, .rxShiftNinth, .rxParityErr,
    .noise_fault_bit, .rxStopZero, .rxBreakSeen, .rxIdleSeen, .first_sample_slot,
    .rxFalseStart, .rx_pin, .txShiftLoad, .txShifting, .txQueued, .txData, .txNinth,
    .txEmpty, .errIrq, .txIrq, .rxIrq
  );

  asd_engine_model u_asd_engine_model (
    .core_clk, .rxCharDone, .rxShiftData, .rxShiftNinth, .rxParityErr, .noise_fault_bit,
    .rxStopZero, .rxBreakSeen, .rxIdleSeen, .first_sample_slot, .rxFalseStart, .rx_pin,
    .txShiftLoad, .txShifting, .txQueued
  );

  // ----
  // Checks and bus cycles
  // ----
  task automatic cmp8(input asd_byte_t got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd(input asd_addr_t a);
    @(posedge core_clk);
    busAddr <= a;
    busRd <= 1'h1;
    @(posedge core_clk);
    busRd <= 1'h0;
    #1 rdv = busRdata;
  endtask

  task automatic rdc(input asd_addr_t a, input asd_byte_t e);
    rd(a);
    cmp8(rdv, e);
  endtask

  // Plain writes only, never a read-modify-write of data
  task automatic wr(input asd_addr_t a, input asd_byte_t d);
    @(posedge core_clk);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'h1;
    @(posedge core_clk);
    busWr <= 1'h0;
    #1;
  endtask

  task automatic ch(input asd_byte_t d, input logic n = 1'h0, pe = 1'h0, nf = 1'h0, fe = 1'h0);
    u_asd_engine_model.rxChar(d, n, pe, nf, fe);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    err_count++;
    end_of_test();
  end

  // ----
  // Sequence
  // ----
  initial begin
    {busRd, busWr, rxEnable, nineBitMode} = 4'h0;
    {tx_empty_irq_enable, tx_done_irq_enable, rx_full_irq_enable, line_quiet_irq_enable} = 4'h0;
    busAddr = 16'h0000;
    busWdata = 8'h00;
    ce = 1'h1;
    rst = 1'h1;
    err_count = 0;
    num_checks = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'h0;
    #1;
    cmp1(txEmpty, 1'h1);
    cmp1(errIrq, 1'h0);
    rdc(S1, 8'hc0);
    rdc(S2, 8'h00);
    rd(C3);
    cmp8(rdv & 8'h3f, 8'h00);
    rdc(16'h0020, 8'h00);
    wr(S1, 8'h00);
    rdc(S1, 8'hc0);
    wr(C3, 8'hff);
    rd(C3);
    cmp8(rdv & 8'h7f, 8'h7f);
    cmp1(txNinth, 1'h1);
    @(posedge core_clk);
    rxEnable <= 1'h1;
    rx_full_irq_enable <= 1'h1;
    line_quiet_irq_enable <= 1'h1;
    u_asd_engine_model.pulse(IDL);
    rdc(S1, 8'hc0);
    ch(8'h11);
    rdc(S1, 8'he0);
    cmp1(rxIrq, 1'h1);
    rdc(DR, 8'h11);
    u_asd_engine_model.pulse(IDL);
    rdc(S1, 8'hd0);
    cmp1(rxIrq, 1'h1);
    rdc(DR, 8'h11);
    rdc(S1, 8'hc0);
    u_asd_engine_model.pulse(IDL);
    rdc(S1, 8'hc0);
    u_asd_engine_model.pulse(FSS);
    rdc(S2, 8'h01);
    u_asd_engine_model.pulse(FLS);
    rdc(S2, 8'h00);
    u_asd_engine_model.pulse(FSS);
    u_asd_engine_model.pulse(IDL);
    rdc(S2, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(C3, rows[i].en);
      ch(rows[i].d, 1'h0, rows[i].pe, rows[i].nf, rows[i].fe);
      rdc(S1, rows[i].s1);
      cmp1(errIrq, rows[i].err);
      rdc(DR, rows[i].d);
      rdc(S1, 8'hc0);
      cmp1(errIrq, 1'h0);
    end
    wr(C3, 8'h08);
    ch(8'h21);
    ch(8'h22);
    rdc(S1, 8'he8);
    cmp1(errIrq, 1'h1);
    rdc(DR, 8'h21);
    rdc(S1, 8'hc0);
    ch(8'h33);
    rdc(S1, 8'he0);
    ch(8'h44);
    rdc(DR, 8'h33);
    rdc(S1, 8'hc8);
    cmp1(errIrq, 1'h1);
    rdc(DR, 8'h33);
    rdc(S1, 8'hc0);
    cmp1(errIrq, 1'h0);
    @(posedge core_clk);
    nineBitMode <= 1'h1;
    ch(8'h81, 1'h1);
    rd(S1);
    rd(C3);
    cmp1(rdv[7], 1'h1);
    rdc(DR, 8'h81);
    u_asd_engine_model.rxBreak();
    rdc(S1, 8'he2);
    rdc(S2, 8'h02);
    rd(C3);
    cmp1(rdv[7], 1'h0);
    rdc(DR, 8'h00);
    rdc(S2, 8'h00);
    rdc(S1, 8'hc0);
    u_asd_engine_model.rxBreak();
    rdc(S2, 8'h00);
    u_asd_engine_model.lineHigh();
    repeat (4) @(posedge core_clk);
    u_asd_engine_model.rxBreak();
    rdc(S2, 8'h02);
    rd(S1);
    rd(S2);
    rd(DR);
    u_asd_engine_model.lineHigh();
    @(posedge core_clk);
    tx_done_irq_enable <= 1'h1;
    rdc(S1, 8'hc0);
    wr(DR, 8'h96);
    cmp8(txData, 8'h96);
    cmp1(txEmpty, 1'h0);
    rdc(S1, 8'h00);
    cmp1(txIrq, 1'h0);
    u_asd_engine_model.txLoad();
    rdc(S1, 8'h80);
    cmp1(txIrq, 1'h0);
    u_asd_engine_model.txStop();
    repeat (2) @(posedge core_clk);
    rdc(S1, 8'hc0);
    cmp1(txIrq, 1'h1);
    @(posedge core_clk);
    tx_done_irq_enable <= 1'h0;
    tx_empty_irq_enable <= 1'h1;
    wr(DR, 8'h3c);
    cmp1(txEmpty, 1'h0);
    u_asd_engine_model.txLoad();
    u_asd_engine_model.txStop();
    wr(DR, 8'h5d);
    cmp1(txEmpty, 1'h1);
    repeat (2) @(posedge core_clk);
    cmp1(txIrq, 1'h1);
    ch(8'h7e);
    rd(S1);
    rd(DR);
    @(posedge core_clk);
    rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    rdc(DR, 8'h7e);
    cmp8(txData, 8'h5d);
    rdc(S1, 8'hc0);
    end_of_test();
  end
endmodule
